// ### verilog/cansf_cfg.svh
/*
 Offsets, field positions, reset words and the APB address width of the CAN status block.
 Assumes inclusion by bare name from every file that needs the constants.
*/
// Functional notes
// R1: Bit 0 shows initialization mode, hardware only
// R2: Bit 1 shows sleep mode, hardware only
// R3: Error event sets bit 2; one clears
// R4: Start of frame in sleep sets wakeup flag
// R5: Sleep entry sets bit 4; exit clears
// R6: Bit 8 shows transmission in progress
// R7: Bit 9 shows reception in progress
// R8: Bit 10 holds last sampled receive value
// R9: Bit 11 shows present receive pin level
// R10: Main status resets to 0x0000_0c02
// R11: Request done set on finish, cleared on request
// R12: Success bit set on success, cleared on failure
// R13: Arbitration lost sets per-mailbox bit
// R14: Bus error failure sets mailbox 0 bit 3
// R15: Abort bit set by software, cleared on removal
// R16: Transmit status resets to 0x1c00_0000
// R17: Mailbox 1 failure sets bit 11
// R18: Software writes control bit 0 for initialization
// R19: Zero writes keep flags; reserved bits read zero
`ifndef CANSF_CFG_SVH
`define CANSF_CFG_SVH

`define CANSF_AW          12
`define CANSF_OFS_MCTRL   12'h000
`define CANSF_OFS_MSTS    12'h004
`define CANSF_OFS_TXSTS   12'h008
`define CANSF_OFS_IMASK   12'h014

`define CANSF_MC_INIT     0
`define CANSF_MC_SLEEP    1
`define CANSF_MC_AWUP     5

`define CANSF_MS_INIT     0
`define CANSF_MS_SLEEP    1
`define CANSF_MS_ERR      2
`define CANSF_MS_WUP      3
`define CANSF_MS_SLP      4
`define CANSF_MS_TX       8
`define CANSF_MS_RX       9
`define CANSF_MS_LSAM     10
`define CANSF_MS_PIN      11

`define CANSF_TX_DONE     0
`define CANSF_TX_OK       1
`define CANSF_TX_ARB      2
`define CANSF_TX_FAIL     3
`define CANSF_TX_ABORT0   7
`define CANSF_TX_STRIDE   8
`define CANSF_TX_EMPTY0   26
`define CANSF_NMBX        2

`define CANSF_MCTRL_RST   32'h0001_0002
`define CANSF_MSTS_RST    32'h0000_0c02
`define CANSF_TXSTS_RST   32'h1c00_0000

`endif

// ### verilog/cansf_pkg.sv
/*
 Types of the CAN status block: operating mode and the packed state record.
 Assumes the constants header is compiled alongside.
*/
package cansf_pkg;

    typedef enum logic [2:0] {
        CANSF_MODE_SLEEP  = 3'b001,
        CANSF_MODE_INIT   = 3'b010,
        CANSF_MODE_NORMAL = 3'b100
    } cansf_mode_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq;
        logic        init_req;
        logic        sleep_req;
        logic        auto_wake;
        cansf_mode_t mode;
        logic        err_flag;
        logic        wake_flag;
        logic        sleep_flag;
        logic        tx_now;
        logic        rx_now;
        logic        last_sample;
        logic        pin_level;
        logic [1:0]  done;
        logic [1:0]  ok;
        logic [1:0]  arb;
        logic [1:0]  fail;
        logic        abort0;
        logic [1:0]  empty;
        logic [4:2]  mask;
    } cansf_state_t;

endpackage

// ### verilog/cansf_sync.sv
/*
 Two-flop synchroniser for one level from outside the clock domain.
 Assumes the input may change at any time relative to clock_in.
*/
`timescale 1ns/1ps
module cansf_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    // Level
    input  wire logic level_in,
    output logic      level_out
);

    logic meta_q;
    logic sync_q;

    // First stage feeds only the second
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= level_in;
            sync_q <= meta_q;
        end
    end

    assign level_out = sync_q;

endmodule

// ### verilog/cansf_top.sv
/*
 CAN status block: mode state machine, main status and transmit mailbox status
 flags, interrupt mask, APB slave.
 Assumes the protocol engine on the same clock supplies event pulses and levels;
 the receive pin is asynchronous.
*/
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "cansf_cfg.svh"
module cansf_top (
    // Clock and reset
    input  wire logic                    clock_in,
    input  wire logic                    reset_n_in,
    // APB slave
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [`CANSF_AW-1:0]    paddr_in,
    input  wire logic [31:0]             pwdata_in,
    output logic      [31:0]             prdata_out,
    output logic                         pready_out,
    output logic                         pslverr_out,
    // Protocol engine status
    input  wire logic                    rx_pin_in,
    input  wire logic                    sample_strobe_in,
    input  wire logic                    bus_idle_in,
    input  wire logic                    tx_active_in,
    input  wire logic                    rx_active_in,
    input  wire logic                    error_event_in,
    // Mailbox events
    input  wire logic [`CANSF_NMBX-1:0]  mbx_request_in,
    input  wire logic [`CANSF_NMBX-1:0]  mbx_done_in,
    input  wire logic [`CANSF_NMBX-1:0]  mbx_tx_ok_in,
    input  wire logic [`CANSF_NMBX-1:0]  mbx_arb_lost_in,
    input  wire logic [`CANSF_NMBX-1:0]  mbx_tx_err_in,
    input  wire logic [`CANSF_NMBX-1:0]  mbx_pending_in,
    input  wire logic                    mbx0_removed_in,
    // Control outputs
    output logic                         init_mode_request_out,
    output logic                         sleep_mode_request_out,
    output logic                         auto_wakeup_out,
    output logic                         mbx0_abort_out,
    output logic                         irq_out
);

    localparam logic [31:0] MCTRL_RST = `CANSF_MCTRL_RST;
    localparam logic [31:0] MSTS_RST  = `CANSF_MSTS_RST;
    localparam logic [31:0] TXSTS_RST = `CANSF_TXSTS_RST;

    cansf_pkg::cansf_state_t st_q;
    cansf_pkg::cansf_state_t st_d;
    logic                    rx_sync;

    cansf_sync #(
        .RESET_VAL (1'b1)
    ) u_rx_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .level_in   (rx_pin_in),
        .level_out  (rx_sync)
    );

    // Reset record built from the documented reset words
    function automatic cansf_pkg::cansf_state_t rst_state();
        cansf_pkg::cansf_state_t r;
        r             = '0;
        r.init_req    = MCTRL_RST[`CANSF_MC_INIT];
        r.sleep_req   = MCTRL_RST[`CANSF_MC_SLEEP];
        r.auto_wake   = MCTRL_RST[`CANSF_MC_AWUP];
        r.mode        = MSTS_RST[`CANSF_MS_SLEEP] ? cansf_pkg::CANSF_MODE_SLEEP
                                                  : cansf_pkg::CANSF_MODE_NORMAL; // R10
        r.last_sample = MSTS_RST[`CANSF_MS_LSAM]; // R10
        r.pin_level   = MSTS_RST[`CANSF_MS_PIN]; // R10
        r.empty       = TXSTS_RST[`CANSF_TX_EMPTY0 +: 2]; // R16
        return r;
    endfunction

    // Set wins over any clear
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    function automatic logic [31:0] msts_word(input cansf_pkg::cansf_state_t s);
        logic [31:0] w;
        w                  = 32'h0000_0000; // R19
        w[`CANSF_MS_INIT]  = (s.mode == cansf_pkg::CANSF_MODE_INIT); // R1
        w[`CANSF_MS_SLEEP] = (s.mode == cansf_pkg::CANSF_MODE_SLEEP); // R2
        w[`CANSF_MS_ERR]   = s.err_flag;
        w[`CANSF_MS_WUP]   = s.wake_flag;
        w[`CANSF_MS_SLP]   = s.sleep_flag;
        w[`CANSF_MS_TX]    = s.tx_now; // R6
        w[`CANSF_MS_RX]    = s.rx_now; // R7
        w[`CANSF_MS_LSAM]  = s.last_sample; // R8
        w[`CANSF_MS_PIN]   = s.pin_level; // R9
        return w;
    endfunction

    function automatic logic [31:0] txsts_word(input cansf_pkg::cansf_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int m = 0; m < `CANSF_NMBX; m++) begin
            w[m*`CANSF_TX_STRIDE + `CANSF_TX_DONE] = s.done[m];
            w[m*`CANSF_TX_STRIDE + `CANSF_TX_OK]   = s.ok[m];
            w[m*`CANSF_TX_STRIDE + `CANSF_TX_ARB]  = s.arb[m];
            w[m*`CANSF_TX_STRIDE + `CANSF_TX_FAIL] = s.fail[m];
            w[`CANSF_TX_EMPTY0 + m]                = s.empty[m];
        end
        w[`CANSF_TX_ABORT0]       = s.abort0;
        // Third mailbox lives elsewhere; its empty bit stays set here
        w[`CANSF_TX_EMPTY0 + 2]   = TXSTS_RST[`CANSF_TX_EMPTY0 + 2]; // R16
        return w;
    endfunction

    function automatic logic addr_mapped(input logic [`CANSF_AW-1:0] a);
        return (a == `CANSF_OFS_MCTRL) || (a == `CANSF_OFS_MSTS) ||
               (a == `CANSF_OFS_TXSTS) || (a == `CANSF_OFS_IMASK);
    endfunction

    function automatic logic [31:0] rd_word(input logic [`CANSF_AW-1:0] a,
                                            input cansf_pkg::cansf_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `CANSF_OFS_MCTRL: begin
                w[`CANSF_MC_INIT]  = s.init_req;
                w[`CANSF_MC_SLEEP] = s.sleep_req;
                w[`CANSF_MC_AWUP]  = s.auto_wake;
            end
            `CANSF_OFS_MSTS: begin
                w = msts_word(s);
            end
            `CANSF_OFS_TXSTS: begin
                w = txsts_word(s);
            end
            `CANSF_OFS_IMASK: begin
                w[`CANSF_MS_SLP:`CANSF_MS_ERR] = s.mask;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    logic setup;
    logic wr;
    logic wr_mctrl;
    logic wr_msts;
    logic wr_txsts;
    logic wr_imask;
    logic sof;

    // Read data is captured in the setup cycle, no wait state
    assign setup    = psel_in && !penable_in;
    assign wr       = psel_in && penable_in && pwrite_in && st_q.ready;
    assign wr_mctrl = wr && (paddr_in == `CANSF_OFS_MCTRL);
    assign wr_msts  = wr && (paddr_in == `CANSF_OFS_MSTS);
    assign wr_txsts = wr && (paddr_in == `CANSF_OFS_TXSTS);
    assign wr_imask = wr && (paddr_in == `CANSF_OFS_IMASK);
    // Recessive to dominant edge on the synchronised line
    assign sof      = (st_q.mode == cansf_pkg::CANSF_MODE_SLEEP) && st_q.pin_level && !rx_sync;

    always_comb begin
        st_d        = st_q;
        st_d.ready  = setup;
        st_d.slverr = setup && !addr_mapped(paddr_in);
        st_d.rdata  = setup ? rd_word(paddr_in, st_q) : 32'h0000_0000;

        if (wr_mctrl) begin
            st_d.init_req  = pwdata_in[`CANSF_MC_INIT]; // R18
            st_d.sleep_req = pwdata_in[`CANSF_MC_SLEEP];
            st_d.auto_wake = pwdata_in[`CANSF_MC_AWUP];
        end
        // Hardware wakeup drops the sleep request
        if (sof && st_q.auto_wake) begin
            st_d.sleep_req = 1'b0;
        end
        if (wr_imask) begin
            st_d.mask = pwdata_in[`CANSF_MS_SLP:`CANSF_MS_ERR];
        end

        case (st_q.mode)
            cansf_pkg::CANSF_MODE_SLEEP: begin
                if (st_q.init_req) begin
                    st_d.mode = cansf_pkg::CANSF_MODE_INIT; // R1
                end else if (!st_q.sleep_req) begin
                    st_d.mode = cansf_pkg::CANSF_MODE_NORMAL; // R2
                end
            end
            cansf_pkg::CANSF_MODE_INIT: begin
                if (st_q.init_req) begin
                    st_d.mode = cansf_pkg::CANSF_MODE_INIT;
                end else if (st_q.sleep_req) begin
                    st_d.mode = cansf_pkg::CANSF_MODE_SLEEP;
                end else if (bus_idle_in) begin
                    // Join the bus only once it is seen idle
                    st_d.mode = cansf_pkg::CANSF_MODE_NORMAL; // R1
                end
            end
            cansf_pkg::CANSF_MODE_NORMAL: begin
                if (st_q.init_req) begin
                    st_d.mode = cansf_pkg::CANSF_MODE_INIT; // R1
                end else if (st_q.sleep_req && !st_q.tx_now && !st_q.rx_now) begin
                    // Sleep waits for the current frame to end
                    st_d.mode = cansf_pkg::CANSF_MODE_SLEEP; // R2
                end
            end
            default: begin
                st_d.mode = cansf_pkg::CANSF_MODE_SLEEP;
            end
        endcase

        st_d.err_flag  = flag_next(st_q.err_flag, error_event_in,
                                   wr_msts && pwdata_in[`CANSF_MS_ERR]); // R3
        st_d.wake_flag = flag_next(st_q.wake_flag, sof,
                                   wr_msts && pwdata_in[`CANSF_MS_WUP]); // R4
        st_d.sleep_flag = flag_next(st_q.sleep_flag,
                                    (st_d.mode == cansf_pkg::CANSF_MODE_SLEEP) &&
                                    (st_q.mode != cansf_pkg::CANSF_MODE_SLEEP),
                                    (wr_msts && pwdata_in[`CANSF_MS_SLP]) ||
                                    (st_d.mode != cansf_pkg::CANSF_MODE_SLEEP)); // R5

        st_d.tx_now    = tx_active_in; // R6
        st_d.rx_now    = rx_active_in; // R7
        st_d.pin_level = rx_sync; // R9
        if (sample_strobe_in) begin
            st_d.last_sample = rx_sync; // R8
        end

        for (int m = 0; m < `CANSF_NMBX; m++) begin
            st_d.done[m] = flag_next(st_q.done[m], mbx_done_in[m], mbx_request_in[m] ||
                           (wr_txsts && pwdata_in[m*`CANSF_TX_STRIDE + `CANSF_TX_DONE])); // R11
            st_d.ok[m]   = flag_next(st_q.ok[m], mbx_tx_ok_in[m],
                           mbx_arb_lost_in[m] || mbx_tx_err_in[m] ||
                           (wr_txsts && pwdata_in[m*`CANSF_TX_STRIDE + `CANSF_TX_OK])); // R12
            st_d.arb[m]  = flag_next(st_q.arb[m], mbx_arb_lost_in[m],
                           wr_txsts && pwdata_in[m*`CANSF_TX_STRIDE + `CANSF_TX_ARB]); // R13
            st_d.fail[m] = flag_next(st_q.fail[m], mbx_tx_err_in[m],
                           wr_txsts && pwdata_in[m*`CANSF_TX_STRIDE + `CANSF_TX_FAIL]); // R14
            st_d.empty[m] = !mbx_pending_in[m];
        end

        // Abort only takes hold while a message waits
        if (!mbx_pending_in[0] || mbx0_removed_in) begin
            st_d.abort0 = 1'b0; // R15
        end else if (wr_txsts && pwdata_in[`CANSF_TX_ABORT0]) begin
            st_d.abort0 = 1'b1; // R15
        end

        st_d.irq = |({st_d.sleep_flag, st_d.wake_flag, st_d.err_flag} & st_d.mask);
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= rst_state();
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata_out             = st_q.rdata;
    assign pready_out             = st_q.ready;
    assign pslverr_out            = st_q.slverr;
    assign init_mode_request_out  = st_q.init_req;
    assign sleep_mode_request_out = st_q.sleep_req;
    assign auto_wakeup_out        = st_q.auto_wake;
    assign mbx0_abort_out         = st_q.abort0;
    assign irq_out                = st_q.irq;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_sleep_entry;
        (st_q.mode != cansf_pkg::CANSF_MODE_SLEEP) ##1 (st_q.mode == cansf_pkg::CANSF_MODE_SLEEP);
    endsequence

    sequence s_sleep_exit;
        (st_q.mode == cansf_pkg::CANSF_MODE_SLEEP) ##1 (st_q.mode != cansf_pkg::CANSF_MODE_SLEEP);
    endsequence

    sequence s_pin_high;
        rx_pin_in [*4];
    endsequence

    a_init_ack_follow: assert property ( // R1
        st_q.init_req |=> (st_q.mode == cansf_pkg::CANSF_MODE_INIT))
        else $error("init request not acknowledged");

    a_sleep_ack_exit: assert property ( // R2
        (st_q.mode == cansf_pkg::CANSF_MODE_SLEEP) && !st_q.sleep_req && !st_q.init_req
        |=> (st_q.mode == cansf_pkg::CANSF_MODE_NORMAL))
        else $error("sleep not left");

    a_err_flag_set: assert property ( // R3
        error_event_in |=> st_q.err_flag)
        else $error("error flag missed");

    a_wake_flag_sof: assert property ( // R4
        sof |=> st_q.wake_flag)
        else $error("wakeup flag missed");

    a_sleep_flag_entry: assert property ( // R5
        s_sleep_entry |-> st_q.sleep_flag)
        else $error("sleep entry flag missed");

    a_sleep_flag_exit: assert property ( // R5
        s_sleep_exit |-> !st_q.sleep_flag)
        else $error("sleep flag not cleared on exit");

    a_status_read_tx: assert property ( // R6
        setup && !st_q.ready && (paddr_in == `CANSF_OFS_MSTS)
        |=> prdata_out[`CANSF_MS_TX] == $past(st_q.tx_now) &&
            prdata_out[`CANSF_MS_RX] == $past(st_q.rx_now))
        else $error("status read mismatch");

    a_last_sample_take: assert property ( // R8
        sample_strobe_in |=> st_q.last_sample == $past(rx_sync))
        else $error("last sample not taken");

    a_pin_level_lag: assert property ( // R9
        s_pin_high |-> st_q.pin_level)
        else $error("pin level not shown");

    a_done_flag_set: assert property ( // R11
        mbx_done_in[0] |=> st_q.done[0])
        else $error("request done flag missed");

    a_done_flag_clear: assert property ( // R11
        mbx_request_in[1] && !mbx_done_in[1] |=> !st_q.done[1])
        else $error("request done flag not cleared");

    a_ok_after_fail: assert property ( // R12
        (mbx_arb_lost_in[1] || mbx_tx_err_in[1]) && !mbx_tx_ok_in[1] |=> !st_q.ok[1])
        else $error("success flag kept after failure");

    a_arb_flag_set: assert property ( // R13
        mbx_arb_lost_in[0] |=> st_q.arb[0])
        else $error("arbitration lost flag missed");

    a_fail0_flag_set: assert property ( // R14
        mbx_tx_err_in[0] |=> st_q.fail[0])
        else $error("mailbox 0 error flag missed");

    a_fail1_flag_set: assert property ( // R17
        mbx_tx_err_in[1] |=> st_q.fail[1])
        else $error("mailbox 1 error flag missed");

    a_abort_idle: assert property ( // R15
        !mbx_pending_in[0] |=> !mbx0_abort_out)
        else $error("abort held without pending message");

    a_reserved_zero: assert property ( // R19
        pready_out && psel_in && (paddr_in == `CANSF_OFS_MSTS)
        |-> prdata_out[31:12] == 20'h0_0000 && prdata_out[7:5] == 3'h0)
        else $error("reserved status bits not zero");

endmodule

// ### dv/cansf_bus_model.sv
/*
 Far side of the status block: a CAN bus node seen through the transceiver.
 Assumes one clock; a frame is a dominant stretch with a sample strobe per cycle.
*/
`timescale 1ns/1ps
module cansf_bus_model #(
    parameter int FLEN = 20
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    // Frame start from the bench
    input  wire logic frame_in,
    // Bus side
    output logic      rx_pin_out,
    output logic      strobe_out,
    output logic      rx_active_out,
    output logic      bus_idle_out
);
    int cnt_q;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= 0;
        end else if (frame_in && cnt_q == 0) begin
            cnt_q <= FLEN;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    // Pull-up keeps the line recessive between frames
    assign rx_pin_out    = (cnt_q == 0);
    assign strobe_out    = (cnt_q != 0);
    assign rx_active_out = (cnt_q != 0);
    assign bus_idle_out  = (cnt_q == 0);
endmodule

// ### dv/cansf_top_tb.sv
/*
 Self-checking bench of the CAN status block over APB.
 Assumes the bus model file is compiled first.
*/
`timescale 1ns/1ps
`include "cansf_cfg.svh"
module cansf_top_tb;
    localparam logic [11:0] CT = `CANSF_OFS_MCTRL;
    localparam logic [11:0] MS = `CANSF_OFS_MSTS;
    localparam logic [11:0] TX = `CANSF_OFS_TXSTS;
    localparam logic [11:0] IM = `CANSF_OFS_IMASK;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel  = 1'b0;
    logic        pen   = 1'b0;
    logic        pwr   = 1'b0;
    logic [11:0] pa    = 12'h000;
    logic [31:0] pwd   = 32'h0000_0000;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        rxp;
    logic        stb;
    logic        idle;
    logic        rxa;
    logic        txa   = 1'b0;
    logic        frm   = 1'b0;
    logic [11:0] ev    = 12'h000;
    logic [1:0]  pend  = 2'h0;
    logic        abt;
    logic        irq;
    logic        imr;
    logic        smr;
    logic        awo;
    logic [31:0] rv;
    logic        sv;
    int          err_total  = 0;
    int          n_compared = 0;

    always #10 clk = ~clk;

    cansf_bus_model u_bus (.clock_in(clk), .reset_n_in(rst_n), .frame_in(frm),
        .rx_pin_out(rxp), .strobe_out(stb), .rx_active_out(rxa), .bus_idle_out(idle));

    // Event pulses: request, done, ok, arb, error per mailbox, then error, removed
    cansf_top u_dut (.clock_in(clk), .reset_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .rx_pin_in(rxp),
        .sample_strobe_in(stb), .bus_idle_in(idle), .tx_active_in(txa),
        .rx_active_in(rxa), .error_event_in(ev[10]), .mbx_request_in(ev[1:0]),
        .mbx_done_in(ev[3:2]), .mbx_tx_ok_in(ev[5:4]), .mbx_arb_lost_in(ev[7:6]),
        .mbx_tx_err_in(ev[9:8]), .mbx_pending_in(pend), .mbx0_removed_in(ev[11]),
        .init_mode_request_out(imr), .sleep_mode_request_out(smr), .auto_wakeup_out(awo),
        .mbx0_abort_out(abt), .irq_out(irq));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Gap before setup lets earlier state changes settle
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        repeat (2) @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        // No wait-state limit here; a hang is left to the watchdog
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rv = prd;
        sv = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rv & m);
    endtask

    task automatic irqc(input logic e);
        @(negedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= 12'h000;
    endtask

    task automatic t_reset;
        rdc("main rst", MS, 32'hffff_ffff, 32'h0000_0c02);
        rdc("tx rst", TX, 32'hffff_ffff, 32'h1c00_0000);
        bus(1'b1, 12'h0fc, 32'hffff_ffff);
        chk("slverr", 32'h1, {31'h0, sv});
        rdc("unmapped", 12'h0fc, 32'hffff_ffff, 32'h0);
        bus(1'b1, MS, 32'hffff_ffff);
        rdc("main ro", MS, 32'hffff_ffff, 32'h0000_0c02);
        $display("test reset done");
    endtask

    task automatic t_wake;
        bus(1'b1, IM, 32'h1c);
        bus(1'b1, CT, 32'h22);
        @(posedge clk) frm <= 1'b1;
        @(posedge clk) frm <= 1'b0;
        repeat (6) @(posedge clk);
        rdc("in frame", MS, 32'he00, 32'h200);
        repeat (20) @(posedge clk);
        rdc("woken", MS, 32'he1f, 32'h808);
        rdc("auto wake", CT, 32'hffff_ffff, 32'h20);
        chk("ctl out", 32'h1, {29'h0, imr, smr, awo});
        irqc(1'b1);
        bus(1'b1, MS, 32'h8);
        rdc("wake clr", MS, 32'h8, 32'h0);
        irqc(1'b0);
        $display("test wake done");
    endtask

    task automatic t_mode;
        bus(1'b1, CT, 32'h1);
        rdc("init", MS, 32'h13, 32'h1);
        chk("ctl out", 32'h4, {29'h0, imr, smr, awo});
        bus(1'b1, CT, 32'h0);
        rdc("normal", MS, 32'h13, 32'h0);
        bus(1'b1, CT, 32'h2);
        rdc("sleep", MS, 32'h13, 32'h12);
        irqc(1'b1);
        bus(1'b1, MS, 32'h0);
        rdc("zero keeps", MS, 32'h13, 32'h12);
        bus(1'b1, MS, 32'h10);
        rdc("sleep sw clr", MS, 32'h13, 32'h2);
        bus(1'b1, CT, 32'h0);
        bus(1'b1, CT, 32'h2);
        bus(1'b1, CT, 32'h0);
        rdc("sleep hw clr", MS, 32'h13, 32'h0);
        irqc(1'b0);
        bus(1'b1, CT, 32'h2);
        bus(1'b1, CT, 32'h3);
        rdc("sleep to init", MS, 32'h13, 32'h1);
        bus(1'b1, CT, 32'h2);
        rdc("init to sleep", MS, 32'h13, 32'h12);
        bus(1'b1, CT, 32'h0);
        $display("test mode done");
    endtask

    task automatic t_status;
        @(posedge clk) txa <= 1'b1;
        rdc("tx now", MS, 32'h300, 32'h100);
        @(posedge clk) txa <= 1'b0;
        rdc("tx idle", MS, 32'h300, 32'h0);
        pulse(10);
        rdc("err set", MS, 32'h4, 32'h4);
        irqc(1'b1);
        bus(1'b1, IM, 32'h0);
        irqc(1'b0);
        bus(1'b1, MS, 32'h4);
        rdc("err clr", MS, 32'h4, 32'h0);
        $display("test status done");
    endtask

    task automatic t_mbx;
        for (int m = 0; m < 2; m++) begin
            pulse(2 + m);
            rdc("done", TX, 32'hf << 8 * m, 32'h1 << 8 * m);
            pulse(m);
            rdc("done hw clr", TX, 32'hf << 8 * m, 32'h0);
            pulse(4 + m);
            rdc("ok", TX, 32'hf << 8 * m, 32'h2 << 8 * m);
            pulse(6 + m);
            rdc("arb", TX, 32'hf << 8 * m, 32'h4 << 8 * m);
            pulse(8 + m);
            rdc("fail", TX, 32'hf << 8 * m, 32'hc << 8 * m);
            bus(1'b1, TX, 32'hf << 8 * m);
            rdc("w1c", TX, 32'hffff_ffff, 32'h1c00_0000);
        end
        $display("test mailbox done");
    endtask

    task automatic t_abort;
        @(posedge clk) pend <= 2'h1;
        rdc("pending", TX, 32'hffff_ffff, 32'h1800_0000);
        bus(1'b1, TX, 32'h80);
        rdc("abort", TX, 32'h80, 32'h80);
        chk("abort out", 32'h1, {31'h0, abt});
        pulse(11);
        rdc("abort clr", TX, 32'h80, 32'h0);
        @(posedge clk) pend <= 2'h0;
        bus(1'b1, TX, 32'h80);
        rdc("abort idle", TX, 32'h80, 32'h0);
        $display("test abort done");
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_wake();
        t_mode();
        t_status();
        t_mbx();
        t_abort();
        test_done();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule
